// ---- config_shadow_loader.sv ----
// Purpose: Load configuration words from flash into shadow bytes at every reset
// Assumes: Flash read port and all consumers share clk; rst covers every reset
// Notes: Consumers must stay in reset until cfg_ready rises
//
// Functional notes
// - On power-on reset copy both packed flash words into shadow registers.
// - Unimplemented bits of shadows and packed words read as one.
// - PWM fields exist on motor parts only; elsewhere they read one.
// - Code-read guard zero protects all program memory; one leaves it open.
// - Program-write guard zero blocks user program writes; one allows them.
// - Two-speed start runs on fast RC, then switches once source is ready.
// - PWM key guard one requires unlock key before PWM register writes.
// - Window size field gives 24, 37.5, 50 or 75 percent window.
// - Initial source field picks the clock; switching changes wait for reset.
// - Mode 1x disables switching and monitor; 01 switching; 00 both.
// - Remap-once one allows a single pin-select change; zero allows many.
// - Outside crystal modes second oscillator pin is clock out or GPIO.
// - Primary mode decodes off, high-speed, medium-speed crystal or external clock.
// - Watchdog force-on keeps watchdog running; otherwise software controls it.
// - Window-off one gives non-window mode; zero gives window mode.
// - Prescale choice one divides by 128, zero by 32.
// - Reload shadows from flash on every kind of device reset.
// - Shadow bits are read only; programmed reads zero, unprogrammed one.
`timescale 1ns/1ps
`include "config_loader_defines.svh"
module config_shadow_loader import config_loader_pkg::*; #(
    parameter bit MOTOR_VARIANT = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    // Flash read port
    output logic flash_rd_req,
    output logic [23:0] flash_rd_addr,
    input wire logic flash_rd_valid,
    input wire logic [23:0] flash_rd_data,
    // Table read port into configuration space
    input wire logic tbl_rd_en,
    input wire logic [23:0] tbl_rd_addr,
    output logic tbl_rd_valid,
    output logic [23:0] tbl_rd_data,
    // Consumer side
    output logic cfg_ready,
    output cfg_decoded_t cfg,
    input wire logic osc_source_ready,
    output logic [2:0] osc_active_source,
    output logic osc_switch_done,
    input wire logic watchdog_soft_on,
    output logic watchdog_run,
    input wire logic remap_write_req,
    output logic remap_write_grant,
    input wire logic prog_write_req,
    output logic prog_write_grant,
    input wire logic code_read_req,
    output logic code_read_grant,
    input wire logic pwm_write_req,
    input wire logic pwm_unlocked,
    output logic pwm_write_grant
);

    typedef struct packed {
        loader_state_t state;
        logic [23:0] word_high;
        logic [23:0] word_low;
        shadow_set_t shadows;
        cfg_decoded_t cfg;
        logic flash_req;
        logic [23:0] flash_addr;
        logic rd_valid;
        logic [23:0] rd_data;
        logic ready;
        logic switch_done;
        logic [2:0] active_source;
        logic wdt_run;
        logic remap_used;
        logic remap_grant;
        logic prog_grant;
        logic code_grant;
        logic pwm_grant;
    } loader_regs_t;

    // Shadows come up unprogrammed, so every field reads as one until loaded
    localparam loader_regs_t REGS_RESET = '{
        state: LD_REQ_HIGH,
        word_high: `WORD_RESET,
        word_low: `WORD_RESET,
        shadows: {6{`SHADOW_RESET}},
        active_source: `OSC_FAST_RC,
        default: '0
    };

    loader_regs_t q;
    loader_regs_t d;
    shadow_set_t unpacked;
    cfg_decoded_t decoded;

    shadow_unpack #(
        .MOTOR_VARIANT(MOTOR_VARIANT)
    ) u_unpack (
        .word_high(q.word_high),
        .word_low(q.word_low),
        .shadows(unpacked)
    );

    config_decode u_decode (
        .shadows(unpacked),
        .cfg(decoded)
    );

    // A shadow byte is eight bits wide; the rest of the word reads as ones
    function automatic logic [23:0] pad_byte(input logic [7:0] b);
        return {`BYTE_PAD_ONES, b};
    endfunction : pad_byte

    // Flash words keep their unimplemented upper byte at ones
    function automatic logic [23:0] fill_word(input logic [23:0] w);
        return w | `WORD_UNIMPL_MASK;
    endfunction : fill_word

    function automatic logic [23:0] read_map(input logic [23:0] addr,
                                             input loader_regs_t r);
        logic [23:0] data;
        data = `UNMAPPED_READ;
        unique case (addr)
            `CFG_HIGH_ADDR: data = r.word_high;
            `CFG_LOW_ADDR: data = r.word_low;
            `SHD_GLOBAL_PROT_ADDR: data = pad_byte(r.shadows.global_protect);
            `SHD_OSC_SOURCE_ADDR: data = pad_byte(r.shadows.osc_source);
            `SHD_OSC_OPTIONS_ADDR: data = pad_byte(r.shadows.osc_options);
            `SHD_WATCHDOG_ADDR: data = pad_byte(r.shadows.watchdog);
            `SHD_RESET_PIN_ADDR: data = pad_byte(r.shadows.reset_pin);
            `SHD_DEBUG_CHAN_ADDR: data = pad_byte(r.shadows.debug_channel);
            default: data = `UNMAPPED_READ;
        endcase
        return data;
    endfunction : read_map

    always_comb begin
        d = q;
        d.rd_valid = 1'b0;
        d.remap_grant = 1'b0;
        d.prog_grant = 1'b0;
        d.code_grant = 1'b0;
        d.pwm_grant = 1'b0;

        unique case (q.state)
            // Any reset lands here, so every reset reloads the shadows
            LD_REQ_HIGH: begin
                d.flash_req = 1'b1;
                d.flash_addr = `CFG_HIGH_ADDR;
                d.state = LD_WAIT_HIGH;
            end
            LD_WAIT_HIGH: begin
                if (flash_rd_valid) begin
                    d.word_high = fill_word(flash_rd_data);
                    d.flash_req = 1'b0;
                    d.state = LD_REQ_LOW;
                end
            end
            LD_REQ_LOW: begin
                d.flash_req = 1'b1;
                d.flash_addr = `CFG_LOW_ADDR;
                d.state = LD_WAIT_LOW;
            end
            LD_WAIT_LOW: begin
                if (flash_rd_valid) begin
                    d.word_low = fill_word(flash_rd_data);
                    d.flash_req = 1'b0;
                    d.state = LD_UNPACK;
                end
            end
            LD_UNPACK: begin
                d.shadows = unpacked;
                d.cfg = decoded;
                // Two-speed start parks on fast RC until the chosen source is up
                d.switch_done = !decoded.two_speed_startup;
                d.active_source = decoded.two_speed_startup
                    ? `OSC_FAST_RC : decoded.initial_osc_source;
                d.state = LD_DONE;
            end
            LD_DONE: begin
                d.ready = 1'b1;
                if (!q.switch_done && osc_source_ready) begin
                    d.active_source = q.cfg.initial_osc_source;
                    d.switch_done = 1'b1;
                end
                d.wdt_run = q.cfg.watchdog_force_on || watchdog_soft_on;
                if (remap_write_req && !(q.cfg.pin_remap_once && q.remap_used)) begin
                    d.remap_grant = 1'b1;
                    d.remap_used = 1'b1;
                end
                d.prog_grant = prog_write_req && !q.cfg.program_write_block;
                d.code_grant = code_read_req && !q.cfg.code_protect_all;
                d.pwm_grant = pwm_write_req
                    && (!q.cfg.pwm_key_required || pwm_unlocked);
            end
        endcase

        // Shadows and words have no write path; they change only by loading
        if (tbl_rd_en) begin
            d.rd_valid = 1'b1;
            d.rd_data = read_map(tbl_rd_addr, q);
        end
    end

    // Clock switching never touches the initial source: it is reloaded only at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= REGS_RESET;
        end else begin
            q <= d;
        end
    end

    assign flash_rd_req = q.flash_req;
    assign flash_rd_addr = q.flash_addr;
    assign tbl_rd_valid = q.rd_valid;
    assign tbl_rd_data = q.rd_data;
    assign cfg_ready = q.ready;
    assign cfg = q.cfg;
    assign osc_active_source = q.active_source;
    assign osc_switch_done = q.switch_done;
    assign watchdog_run = q.wdt_run;
    assign remap_write_grant = q.remap_grant;
    assign prog_write_grant = q.prog_grant;
    assign code_read_grant = q.code_grant;
    assign pwm_write_grant = q.pwm_grant;

endmodule : config_shadow_loader

// ---- config_loader_defines.svh ----
// Purpose: Addresses, field positions and reset values of the configuration loader
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef CONFIG_LOADER_DEFINES_SVH
`define CONFIG_LOADER_DEFINES_SVH

`define CFG_HIGH_ADDR 24'h00_2bfc
`define CFG_LOW_ADDR 24'h00_2bfe
`define SHD_GLOBAL_PROT_ADDR 24'hf8_0004
`define SHD_OSC_SOURCE_ADDR 24'hf8_0006
`define SHD_OSC_OPTIONS_ADDR 24'hf8_0008
`define SHD_WATCHDOG_ADDR 24'hf8_000a
`define SHD_RESET_PIN_ADDR 24'hf8_000c
`define SHD_DEBUG_CHAN_ADDR 24'hf8_000e

`define SHADOW_RESET 8'hff
`define WORD_RESET 24'hff_ffff
`define WORD_UNIMPL_MASK 24'hff_0000
`define UNMAPPED_READ 24'hff_ffff
`define BYTE_PAD_ONES 16'hffff

`define HI_TWO_SPEED 15
`define HI_PWM_KEY 14
`define HI_PWM_PIN 13
`define HI_WIN_LSB 11
`define HI_OSC_LSB 8
`define HI_CKSM_LSB 6
`define HI_OSC_OUT 5
`define HI_REMAP 4
`define HI_LOW_POL 3
`define HI_I2C_ALT 2
`define HI_POSC_LSB 0

`define LO_ZERO_RES_A 15
`define LO_ZERO_RES_B 14
`define LO_CODE_GUARD 13
`define LO_WRITE_GUARD 12
`define LO_TOOL_RES 11
`define LO_HIGH_POL 10
`define LO_DBG_LSB 8
`define LO_WDT_FORCE 7
`define LO_WIN_OFF 6
`define LO_PLL_WAIT 5
`define LO_PRESCALE 4
`define LO_POST_LSB 0

`define OSC_FAST_RC 3'h0
`define OSC_RESERVED 3'h6
`define POSC_HS 2'h2
`define POSC_MS 2'h1

`define WIN_PM_11 10'h0f0
`define WIN_PM_10 10'h177
`define WIN_PM_01 10'h1f4
`define WIN_PM_00 10'h2ee
`define PRESCALE_DIV_HI 8'h80
`define PRESCALE_DIV_LO 8'h20

`endif

// ---- config_loader_pkg.sv ----
// Purpose: Types shared by the configuration loader modules
// Assumes: Shadow bytes are laid out MSB first as in the shadow map
// Notes: Unused fields are filled with ones by the unpacker
package config_loader_pkg;

    typedef enum logic [2:0] {
        LD_REQ_HIGH, LD_WAIT_HIGH, LD_REQ_LOW, LD_WAIT_LOW, LD_UNPACK, LD_DONE
    } loader_state_t;

    typedef struct packed {
        logic [5:0] unused;
        logic code_read_guard;
        logic program_write_guard;
    } global_protect_t;

    typedef struct packed {
        logic two_speed_startup;
        logic pwm_key_guard;
        logic unused;
        logic [1:0] watchdog_window_size;
        logic [2:0] initial_osc_source;
    } osc_source_shd_t;

    typedef struct packed {
        logic [1:0] clock_switch_monitor_mode;
        logic pin_remap_once;
        logic [1:0] unused;
        logic osc_out_pin_function;
        logic [1:0] primary_osc_mode;
    } osc_options_shd_t;

    typedef struct packed {
        logic watchdog_force_on;
        logic watchdog_window_off;
        logic pll_lock_wait;
        logic watchdog_prescale_choice;
        logic [3:0] watchdog_postscale;
    } watchdog_shd_t;

    typedef struct packed {
        logic pwm_pin_reset_owner;
        logic high_side_polarity;
        logic low_side_polarity;
        logic i2c_alt_pin_choice;
        logic [3:0] unused;
    } reset_pin_shd_t;

    typedef struct packed {
        logic tool_reserved;
        logic unused_hi;
        logic [1:0] zero_reserved;
        logic [1:0] unused_lo;
        logic [1:0] debug_channel_choice;
    } debug_channel_shd_t;

    typedef struct packed {
        global_protect_t global_protect;
        osc_source_shd_t osc_source;
        osc_options_shd_t osc_options;
        watchdog_shd_t watchdog;
        reset_pin_shd_t reset_pin;
        debug_channel_shd_t debug_channel;
    } shadow_set_t;

    typedef struct packed {
        logic code_protect_all;
        logic program_write_block;
        logic two_speed_startup;
        logic pwm_key_required;
        logic [9:0] watchdog_window_permille;
        logic [2:0] initial_osc_source;
        logic osc_source_reserved;
        logic clock_switch_en;
        logic fail_safe_monitor_en;
        logic pin_remap_once;
        logic second_osc_pin_clock_out;
        logic second_osc_pin_gpio;
        logic primary_osc_off;
        logic hs_crystal_mode;
        logic ms_crystal_mode;
        logic ext_clock_mode;
        logic watchdog_force_on;
        logic low_power_rc_osc_stop_allowed;
        logic watchdog_window_mode;
        logic [7:0] watchdog_prescale_div;
    } cfg_decoded_t;

endpackage : config_loader_pkg

// ---- shadow_unpack.sv ----
// Purpose: Spread the two packed flash words over the six shadow bytes
// Assumes: Words already have their unimplemented upper byte forced to ones
// Notes: Purely combinational
`timescale 1ns/1ps
`include "config_loader_defines.svh"
module shadow_unpack import config_loader_pkg::*; #(
    parameter bit MOTOR_VARIANT = 1'b1
) (
    input wire logic [23:0] word_high,
    input wire logic [23:0] word_low,
    output shadow_set_t shadows
);

    // Bits that only exist on motor-control parts read as one elsewhere
    function automatic logic motor_bit(input logic b);
        return MOTOR_VARIANT ? b : 1'b1;
    endfunction : motor_bit

    always_comb begin
        shadows = {6{`SHADOW_RESET}};
        shadows.global_protect.code_read_guard = word_low[`LO_CODE_GUARD];
        shadows.global_protect.program_write_guard = word_low[`LO_WRITE_GUARD];
        shadows.osc_source.two_speed_startup = word_high[`HI_TWO_SPEED];
        shadows.osc_source.pwm_key_guard = motor_bit(word_high[`HI_PWM_KEY]);
        shadows.osc_source.watchdog_window_size = word_high[`HI_WIN_LSB +: 2];
        shadows.osc_source.initial_osc_source = word_high[`HI_OSC_LSB +: 3];
        shadows.osc_options.clock_switch_monitor_mode = word_high[`HI_CKSM_LSB +: 2];
        shadows.osc_options.pin_remap_once = word_high[`HI_REMAP];
        shadows.osc_options.osc_out_pin_function = word_high[`HI_OSC_OUT];
        shadows.osc_options.primary_osc_mode = word_high[`HI_POSC_LSB +: 2];
        shadows.watchdog.watchdog_force_on = word_low[`LO_WDT_FORCE];
        shadows.watchdog.watchdog_window_off = word_low[`LO_WIN_OFF];
        shadows.watchdog.pll_lock_wait = word_low[`LO_PLL_WAIT];
        shadows.watchdog.watchdog_prescale_choice = word_low[`LO_PRESCALE];
        shadows.watchdog.watchdog_postscale = word_low[`LO_POST_LSB +: 4];
        shadows.reset_pin.pwm_pin_reset_owner = motor_bit(word_high[`HI_PWM_PIN]);
        shadows.reset_pin.high_side_polarity = motor_bit(word_low[`LO_HIGH_POL]);
        shadows.reset_pin.low_side_polarity = motor_bit(word_high[`HI_LOW_POL]);
        shadows.reset_pin.i2c_alt_pin_choice = word_high[`HI_I2C_ALT];
        // Reserved bits are copied as programmed so tools can read them back
        shadows.debug_channel.tool_reserved = word_low[`LO_TOOL_RES];
        shadows.debug_channel.zero_reserved = {word_low[`LO_ZERO_RES_A],
                                               word_low[`LO_ZERO_RES_B]};
        shadows.debug_channel.debug_channel_choice = word_low[`LO_DBG_LSB +: 2];
    end

endmodule : shadow_unpack

// ---- config_decode.sv ----
// Purpose: Turn shadow fields into the controls used by clock, watchdog and guards
// Assumes: Shadows are stable after loading
// Notes: Purely combinational; the loader registers the result
`timescale 1ns/1ps
`include "config_loader_defines.svh"
module config_decode import config_loader_pkg::*; (
    input shadow_set_t shadows,
    output cfg_decoded_t cfg
);

    always_comb begin
        cfg.code_protect_all = !shadows.global_protect.code_read_guard;
        cfg.program_write_block = !shadows.global_protect.program_write_guard;
        cfg.two_speed_startup = shadows.osc_source.two_speed_startup;
        cfg.pwm_key_required = shadows.osc_source.pwm_key_guard;
        unique case (shadows.osc_source.watchdog_window_size)
            2'h3: cfg.watchdog_window_permille = `WIN_PM_11;
            2'h2: cfg.watchdog_window_permille = `WIN_PM_10;
            2'h1: cfg.watchdog_window_permille = `WIN_PM_01;
            2'h0: cfg.watchdog_window_permille = `WIN_PM_00;
        endcase
        cfg.initial_osc_source = shadows.osc_source.initial_osc_source;
        cfg.osc_source_reserved = shadows.osc_source.initial_osc_source == `OSC_RESERVED;
        cfg.clock_switch_en = !shadows.osc_options.clock_switch_monitor_mode[1];
        cfg.fail_safe_monitor_en = shadows.osc_options.clock_switch_monitor_mode == 2'h0;
        cfg.pin_remap_once = shadows.osc_options.pin_remap_once;
        cfg.primary_osc_off = shadows.osc_options.primary_osc_mode == 2'h3;
        cfg.hs_crystal_mode = shadows.osc_options.primary_osc_mode == `POSC_HS;
        cfg.ms_crystal_mode = shadows.osc_options.primary_osc_mode == `POSC_MS;
        cfg.ext_clock_mode = shadows.osc_options.primary_osc_mode == 2'h0;
        // Crystal modes own the pin, so the pin function only counts outside them
        cfg.second_osc_pin_clock_out = shadows.osc_options.osc_out_pin_function
            && !cfg.hs_crystal_mode && !cfg.ms_crystal_mode;
        cfg.second_osc_pin_gpio = !shadows.osc_options.osc_out_pin_function
            && !cfg.hs_crystal_mode && !cfg.ms_crystal_mode;
        cfg.watchdog_force_on = shadows.watchdog.watchdog_force_on;
        cfg.low_power_rc_osc_stop_allowed = !shadows.watchdog.watchdog_force_on;
        cfg.watchdog_window_mode = !shadows.watchdog.watchdog_window_off;
        cfg.watchdog_prescale_div = shadows.watchdog.watchdog_prescale_choice
            ? `PRESCALE_DIV_HI : `PRESCALE_DIV_LO;
    end

endmodule : config_decode

// ---- config_shadow_loader_checker.sv ----
// Purpose: Port-level assertions for the loader
// Assumes: One clock, synchronous active-high reset
// Notes: Bind at end of file
`timescale 1ns/1ps
module config_shadow_loader_checker import config_loader_pkg::*; (
    input logic clk,
    input logic rst,
    input logic flash_rd_req,
    input logic [23:0] flash_rd_addr,
    input logic flash_rd_valid,
    input logic tbl_rd_en,
    input logic tbl_rd_valid,
    input logic cfg_ready,
    input cfg_decoded_t cfg,
    input logic [2:0] osc_active_source,
    input logic osc_switch_done,
    input logic watchdog_soft_on,
    input logic watchdog_run,
    input logic remap_write_grant,
    input logic prog_write_req,
    input logic prog_write_grant,
    input logic code_read_req,
    input logic code_read_grant,
    input logic pwm_write_req,
    input logic pwm_unlocked,
    input logic pwm_write_grant
);
    logic remap_seen_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk) begin
        remap_seen_q <= !rst && (remap_seen_q || remap_write_grant);
    end
    sequence high_word_done;
        flash_rd_req && flash_rd_valid && flash_rd_addr == 24'h00_2bfc;
    endsequence
    sequence low_word_next;
        !flash_rd_req ##1 (flash_rd_req && flash_rd_addr == 24'h00_2bfe);
    endsequence
    a_word_order: assert property (high_word_done |=> low_word_next)
        else $error("low word not requested after high word");
    a_req_holds: assert property (flash_rd_req && !flash_rd_valid |=>
        flash_rd_req && $stable(flash_rd_addr)) else $error("flash request dropped");
    a_ready_after_load: assert property ($rose(cfg_ready) |->
        $past(flash_rd_valid, 3) && $past(flash_rd_addr, 3) == 24'h00_2bfe)
        else $error("ready not tied to last word");
    a_ready_holds: assert property (cfg_ready |=> cfg_ready && !flash_rd_req)
        else $error("ready dropped or reload outside reset");
    a_tbl_answer: assert property (tbl_rd_en |=> tbl_rd_valid)
        else $error("table read not answered");
    a_tbl_no_spurious: assert property (!tbl_rd_en |=> !tbl_rd_valid)
        else $error("spurious table answer");
    a_prog_guard: assert property (prog_write_req && cfg_ready |=>
        prog_write_grant == !cfg.program_write_block) else $error("write guard wrong");
    a_code_guard: assert property (code_read_req && cfg_ready |=>
        code_read_grant == !cfg.code_protect_all) else $error("read guard wrong");
    a_pwm_key: assert property (pwm_write_req && cfg_ready |=>
        pwm_write_grant == (!cfg.pwm_key_required || $past(pwm_unlocked)))
        else $error("pwm key guard wrong");
    a_remap_once: assert property (remap_seen_q && cfg.pin_remap_once |->
        !remap_write_grant) else $error("second remap granted");
    a_wdt_follow: assert property (cfg_ready |=>
        watchdog_run == ($past(cfg.watchdog_force_on) || $past(watchdog_soft_on)))
        else $error("watchdog run wrong");
    a_switch_match: assert property (osc_switch_done |->
        osc_active_source == cfg.initial_osc_source) else $error("switch done early");
endmodule : config_shadow_loader_checker

bind config_shadow_loader config_shadow_loader_checker config_shadow_loader_checker_i (.*);

// ---- flash_model.sv ----
// Purpose: Flash holding the two packed configuration words
// Assumes: Bench supplies the programmed words
// Notes: Data toggles outside valid so stale values never pass
`timescale 1ns/1ps
module flash_model (
    input logic clk,
    input logic rst,
    input logic req,
    input logic [23:0] addr,
    input logic [23:0] word_hi,
    input logic [23:0] word_lo,
    input logic [3:0] dly,
    output logic valid,
    output logic [23:0] data
);
    int cnt = 0;
    initial begin
        valid = 1'b0;
        data = 24'h5a_5a5a;
    end
    always @(posedge clk) begin
        valid <= 1'b0;
        data <= ~data;
        if (rst || !req || valid) begin
            cnt <= 0;
        end else if (cnt == int'(dly)) begin
            valid <= 1'b1;
            data <= (addr == 24'h00_2bfc) ? word_hi : word_lo;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : flash_model

// ---- config_shadow_loader_tb.sv ----
// Purpose: Self-checking bench for the configuration shadow loader
// Assumes: Inputs change on the falling edge
// Notes: Eight reload rounds sweep every window, source, switch-mode, primary-mode and guard code
`timescale 1ns/1ps
module config_shadow_loader_tb import config_loader_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic flash_rd_req, flash_rd_valid, tbl_rd_valid, cfg_ready, osc_switch_done;
    logic watchdog_run, remap_write_grant, prog_write_grant, code_read_grant, pwm_write_grant;
    logic [23:0] flash_rd_addr, flash_rd_data, tbl_rd_data;
    logic [23:0] hi = 24'hff_ffff, lo = 24'hff_ffff;
    logic [3:0] dly = 4'h0;
    logic [23:0] tbl_rd_addr = 24'h00_0000;
    logic tbl_rd_en = 1'b0, osc_source_ready = 1'b0, watchdog_soft_on = 1'b0, pwm_unlocked = 1'b0;
    logic [3:0] reqs = 4'h0;
    logic [2:0] osc_active_source;
    cfg_decoded_t cfg;
    int err_total = 0;
    int n_compared = 0;
    logic [9:0] win [4] = '{10'h2ee, 10'h1f4, 10'h177, 10'h0f0};
    logic [23:0] addrs [$] = '{24'h00_2bfc, 24'h00_2bfe, 24'hf8_0004, 24'hf8_0006,
        24'hf8_0008, 24'hf8_000a, 24'hf8_000c, 24'hf8_000e, 24'hf8_0010};
    wire [3:0] grants = {remap_write_grant, prog_write_grant, code_read_grant, pwm_write_grant};
    always #2 clk = ~clk;

    config_shadow_loader #(.MOTOR_VARIANT(1'b1)) config_shadow_loader_i (
        .clk, .rst, .flash_rd_req, .flash_rd_addr, .flash_rd_valid, .flash_rd_data,
        .tbl_rd_en, .tbl_rd_addr, .tbl_rd_valid, .tbl_rd_data, .cfg_ready, .cfg,
        .osc_source_ready, .osc_active_source, .osc_switch_done, .watchdog_soft_on,
        .watchdog_run, .remap_write_req(reqs[3]), .remap_write_grant,
        .prog_write_req(reqs[2]), .prog_write_grant, .code_read_req(reqs[1]),
        .code_read_grant, .pwm_write_req(reqs[0]), .pwm_unlocked, .pwm_write_grant
    );
    flash_model flash_model_i (.clk, .rst, .req(flash_rd_req), .addr(flash_rd_addr),
        .word_hi(hi), .word_lo(lo), .dly, .valid(flash_rd_valid), .data(flash_rd_data));

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_word

    task automatic chk_cfg(input cfg_decoded_t got, input cfg_decoded_t exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t cfg got %h exp %h", $time, got, exp);
        end
    endtask : chk_cfg

    function automatic logic [23:0] exp_shadow(input logic [23:0] a);
        logic [7:0] b;
        case (a)
            24'h00_2bfc: return {8'hff, hi[15:0]};
            24'h00_2bfe: return {8'hff, lo[15:0]};
            24'hf8_0004: b = {6'h3f, lo[13:12]};
            24'hf8_0006: b = {hi[15:14], 1'b1, hi[12:8]};
            24'hf8_0008: b = {hi[7:6], hi[4], 2'h3, hi[5], hi[1:0]};
            24'hf8_000a: b = lo[7:0];
            24'hf8_000c: b = {hi[13], lo[10], hi[3:2], 4'hf};
            24'hf8_000e: b = {lo[11], 1'b1, lo[15:14], 2'h3, lo[9:8]};
            default: return 24'hff_ffff;
        endcase
        return {16'hffff, b};
    endfunction : exp_shadow

    // Fields in declaration order of the decoded struct
    function automatic cfg_decoded_t exp_cfg();
        logic xtal;
        xtal = hi[1:0] == 2'h1 || hi[1:0] == 2'h2;
        return '{!lo[13], !lo[12], hi[15], hi[14], win[hi[12:11]], hi[10:8], hi[10:8] == 3'h6,
            !hi[7], hi[7:6] == 2'h0, hi[4], !xtal && hi[5], !xtal && !hi[5], hi[1:0] == 2'h3,
            hi[1:0] == 2'h2, hi[1:0] == 2'h1, hi[1:0] == 2'h0, lo[7], !lo[7], !lo[6],
            lo[4] ? 8'h80 : 8'h20};
    endfunction : exp_cfg

    task automatic tbl_read(input logic [23:0] a, input logic [23:0] exp);
        @(negedge clk);
        tbl_rd_en = 1'b1;
        tbl_rd_addr = a;
        @(negedge clk);
        tbl_rd_en = 1'b0;
        chk_bit(tbl_rd_valid, 1'b1, "read not answered");
        chk_word(tbl_rd_data, exp, "read data");
    endtask : tbl_read

    task automatic grant(input int k, input logic exp, input string msg);
        @(negedge clk);
        reqs[k] = 1'b1;
        @(negedge clk);
        reqs = 4'h0;
        chk_bit(grants[k], exp, msg);
    endtask : grant

    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        void'($urandom(32'hc600));
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            rst = 1'b1;
            osc_source_ready = 1'b0;
            hi = 24'($urandom);
            lo = 24'($urandom);
            hi[12:8] = {i[1:0], i[2:0]};
            hi[7:6] = i[1:0];
            hi[1:0] = i[1:0];
            lo[15:14] = 2'h0;
            lo[11] = 1'b1;
            lo[13:12] = i[2:1];
            dly = 4'($urandom_range(3));
            repeat (i == 0 ? 20 : 3) @(negedge clk);
            rst = 1'b0;
            tbl_read(24'hf8_0006, 24'hff_ffff);
            repeat (40) if (!cfg_ready) @(negedge clk);
            chk_bit(cfg_ready, 1'b1, "load did not finish");
            foreach (addrs[k]) tbl_read(addrs[k], exp_shadow(addrs[k]));
            chk_cfg(cfg, exp_cfg());
            if (hi[15]) begin
                chk_word(24'(osc_active_source), 24'h00_0000, "not on fast rc");
                @(negedge clk);
                osc_source_ready = 1'b1;
                @(negedge clk);
            end
            chk_word(24'(osc_active_source), 24'(hi[10:8]), "active source");
            chk_bit(osc_switch_done, 1'b1, "switch not done");
            watchdog_soft_on = 1'($urandom);
            repeat (2) @(negedge clk);
            chk_bit(watchdog_run, lo[7] | watchdog_soft_on, "watchdog run");
            pwm_unlocked = 1'($urandom);
            grant(2, lo[12], "program write");
            grant(1, lo[13], "code read");
            grant(0, !hi[14] || pwm_unlocked, "pwm write");
            grant(3, 1'b1, "first remap");
            grant(3, !hi[4], "second remap");
        end
        print_verdict();
    end

    // Eight rounds take under 1000 cycles
    initial begin
        #20000;
        err_total++;
        print_verdict();
    end
endmodule : config_shadow_loader_tb
